// file: hw/llp_loop_unit.sv
// loop command interpreter: addressing, remote/local, clear, polls
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module llp_loop_unit
  import llp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        frame_valid,
  input  wire logic [10:0] frame,
  input  wire logic        sp_req,
  input  wire logic        pp_req,
  input  wire logic [7:0]  pp_in,
  input  wire logic        ev_invalid,
  input  wire logic        ev_selftest,
  input  wire logic        ev_cmd_err,
  input  wire logic        ev_panel_srq,
  input  wire logic        link_state,
  input  wire logic        data_ready,
  output logic      [7:0]  sp_byte,
  output logic             sp_valid,
  output logic      [7:0]  pp_byte,
  output logic             pp_valid,
  output logic             idy_req,
  output logic             queue_clear,
  output logic             meas_abort,
  output logic             mode_normal,
  output logic             direct_exit,
  output logic             remote,
  output logic             lockout,
  output logic             listen_active,
  output logic             talk_active,
  output logic             srq
);
  typedef struct packed {
    logic [4:0]  own_addr;
    logic        srq_data_en;
    logic        remote;
    logic        lockout;
    logic        listen;
    logic        talk;
    logic        ppc_armed;
    logic        pp_en;
    logic        pp_sense;
    logic [2:0]  response_line_select;
    logic        async_mode;
    logic        data_ready_q;
    logic [7:0]  sp_byte;
    logic        sp_valid;
    logic [7:0]  pp_byte;
    logic        pp_valid;
    logic        idy_req;
    logic        dev_clear;
    logic        srq;
    logic        wb_ack;
    logic [31:0] wb_dat;
  } llp_state_t;

  llp_state_t st;
  llp_state_t next_st;

  logic [NUM_EVENTS-1:0] ev_flags;
  logic [NUM_EVENTS-1:0] ev_set;
  logic [NUM_EVENTS-1:0] ev_clr;
  logic [NUM_EVENTS-1:0] enc_clr;
  logic [7:0]            enc_status;
  logic                  enc_srq;

  logic       is_cmd;
  logic [7:0] cb;
  logic       c_lad;
  logic       c_tad;
  logic       c_ppe;
  logic       wb_req;
  logic       pp_bit;

  assign ev_set = {ev_panel_srq, ev_cmd_err, ev_selftest, ev_invalid};
  // only the event actually reported is retired, later ones stay pending
  assign ev_clr = sp_req ? enc_clr : '0;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi++)
    begin : g_ev
      llp_event_flag u_flag
      (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .set     (ev_set[gi]),
        .clr     (ev_clr[gi]),
        .flag    (ev_flags[gi])
      );
    end
  endgenerate

  llp_status_enc u_enc
  (
    .events      (ev_flags),
    .link_state  (link_state),
    .data_ready  (data_ready),
    .srq_data_en (st.srq_data_en),
    .status      (enc_status),
    .clr_sel     (enc_clr),
    .srq         (enc_srq)
  );

  assign is_cmd = frame_valid && (frame[10:8] == FRAME_CMD);
  assign cb     = frame[7:0];
  assign c_lad  = is_cmd && (cb[7:5] == GRP_LAD) && (cb[4:0] != ADDR_NONE);
  assign c_tad  = is_cmd && (cb[7:5] == GRP_TAD) && (cb[4:0] != ADDR_NONE);
  // the enable group code spans the frame class and the top command bit,
  // so the configure command must stay outside the 80-8f block
  assign c_ppe  = is_cmd && (frame[10:7] == GRP_PPE) && (cb[6:4] == 3'h0);
  assign wb_req = wb_cyc_i && wb_stb_i && !st.wb_ack;
  assign pp_bit = st.pp_sense ? st.srq : !st.srq;

  always_comb
  begin
    next_st = st;
    next_st.sp_valid = 1'b0;
    next_st.pp_valid = 1'b0;
    next_st.idy_req = 1'b0;
    next_st.dev_clear = 1'b0;
    next_st.wb_ack = 1'b0;
    next_st.data_ready_q = data_ready;
    next_st.srq = enc_srq;
    if (is_cmd)
    begin
      // any command but EAR ends async mode, and any but PPC while listening the configure window
      next_st.async_mode = (cb == CMD_EAR);
      next_st.ppc_armed = 1'b0;
      if ((cb == CMD_DCL) || ((cb == CMD_SDC) && st.listen))
        next_st.dev_clear = 1'b1;
      if (cb == CMD_REN)
        next_st.remote = 1'b1;
      if ((cb == CMD_GTL) && st.listen)
        next_st.remote = 1'b0;
      if ((cb == CMD_LLO) && st.remote)
        next_st.lockout = 1'b1;
      if (cb == CMD_NRE)
      begin
        next_st.remote = 1'b0;
        next_st.lockout = 1'b0;
      end
      if ((cb == CMD_PPC) && st.listen)
        next_st.ppc_armed = 1'b1;
      if (c_ppe && st.ppc_armed && st.listen)
      begin
        next_st.pp_en = 1'b1;
        next_st.pp_sense = cb[PPE_SENSE_BIT];
        next_st.response_line_select = cb[2:0];
      end
      if ((cb == CMD_PPD) && st.ppc_armed && st.listen)
        next_st.pp_en = 1'b0;
      if (cb == CMD_PPU)
        next_st.pp_en = 1'b0;
      if (c_lad && (cb[4:0] == st.own_addr))
        next_st.listen = 1'b1;
      if (cb == CMD_UNL)
        next_st.listen = 1'b0;
      if (c_tad)
        next_st.talk = (cb[4:0] == st.own_addr);
      if (cb == CMD_UNT)
        next_st.talk = 1'b0;
      // trigger and power down fall through: only async mode and the configure window are cleared
    end
    // identify frame when data turns up, or at once if already waiting
    if (st.async_mode && data_ready && !st.data_ready_q)
      next_st.idy_req = 1'b1;
    if (is_cmd && (cb == CMD_EAR) && data_ready)
      next_st.idy_req = 1'b1;
    if (sp_req)
    begin
      next_st.sp_byte = enc_status;
      next_st.sp_valid = 1'b1;
    end
    if (pp_req)
    begin
      next_st.pp_byte = pp_in;
      if (st.pp_en)
        next_st.pp_byte[st.response_line_select] = pp_in[st.response_line_select] | pp_bit;
      next_st.pp_valid = 1'b1;
    end
    if (wb_req)
    begin
      next_st.wb_ack = 1'b1;
      next_st.wb_dat = '0;
      if (wb_we_i && (wb_adr_i == REG_CTRL))
      begin
        if (wb_sel_i[0])
          next_st.own_addr = wb_dat_i[4:0];
        if (wb_sel_i[1])
          next_st.srq_data_en = wb_dat_i[8];
      end
      else if (!wb_we_i)
      begin
        case (wb_adr_i)
          REG_CTRL:  next_st.wb_dat = {23'h0, st.srq_data_en, 3'h0, st.own_addr};
          REG_STATE: next_st.wb_dat = {21'h0, st.response_line_select, st.pp_sense, st.pp_en,
                                       st.ppc_armed, st.async_mode, st.talk, st.listen,
                                       st.lockout, st.remote};
          REG_SPOLL: next_st.wb_dat = {24'h0, enc_status};
          default:   next_st.wb_dat = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.own_addr <= RST_OWN_ADDR;
      st.srq_data_en <= RST_SRQ_DATA;
      st.sp_byte <= ST_ALL_OK;
    end
    else if (ce)
      st <= next_st;
  end

  assign wb_dat_o      = st.wb_dat;
  assign wb_ack_o      = st.wb_ack;
  assign sp_byte       = st.sp_byte;
  assign sp_valid      = st.sp_valid;
  assign pp_byte       = st.pp_byte;
  assign pp_valid      = st.pp_valid;
  assign idy_req       = st.idy_req;
  assign queue_clear   = st.dev_clear;
  assign meas_abort    = st.dev_clear;
  assign mode_normal   = st.dev_clear;
  assign direct_exit   = st.dev_clear;
  assign remote        = st.remote;
  assign lockout       = st.lockout;
  assign listen_active = st.listen;
  assign talk_active   = st.talk;
  assign srq           = st.srq;

  default clocking cb_main @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  dev_clear_out_a: assert property (ce && is_cmd && (cb == CMD_DCL) |=>
    queue_clear && meas_abort && mode_normal && direct_exit)
    else $error("device clear pulses missing");
  ren_remote_a: assert property (ce && is_cmd && (cb == CMD_REN) |=> remote)
    else $error("remote enable not entered");
  gtl_local_a: assert property (ce && is_cmd && (cb == CMD_GTL)
    |=> remote == ($past(remote) && !$past(st.listen)))
    else $error("go to local wrong");
  llo_gate_a: assert property (ce && is_cmd && (cb == CMD_LLO)
    |=> lockout == ($past(lockout) || $past(remote)))
    else $error("lockout gating wrong");
  nre_local_a: assert property (ce && is_cmd && (cb == CMD_NRE) |=> !remote && !lockout)
    else $error("not remote enable left remote or lockout");
  spoll_answer_a: assert property (ce && sp_req |=> sp_valid && sp_byte[7]
    && (sp_byte[ST_SRQ_BIT] == $past(enc_srq)))
    else $error("serial poll answer wrong");
  ppe_gate_a: assert property (ce && c_ppe && !st.ppc_armed
    |=> st.pp_en == $past(st.pp_en) && st.response_line_select == $past(st.response_line_select))
    else $error("enable accepted without configure");
  ppu_disable_a: assert property (ce && is_cmd && (cb == CMD_PPU) |=> !st.pp_en)
    else $error("unconfigure left poll enabled");
  ppoll_pass_a: assert property (ce && pp_req && !st.pp_en |=> pp_valid
    && (pp_byte == $past(pp_in)))
    else $error("parallel poll byte altered");
  listen_addr_a: assert property (ce && c_lad && (cb[4:0] == st.own_addr)
    ##1 (!ce || !(is_cmd && cb == CMD_UNL))[*2] |-> listen_active)
    else $error("listener not active");
  talk_addr_a: assert property (ce && c_tad |=> talk_active == ($past(cb[4:0]) ==
    $past(st.own_addr)))
    else $error("talk address handling wrong");
  untalk_a: assert property (ce && is_cmd && (cb == CMD_UNT) |=> !talk_active)
    else $error("untalk ignored");
  ear_cancel_a: assert property (ce && is_cmd && (cb != CMD_EAR) |=> !st.async_mode)
    else $error("async mode survived a command");
  ignore_cmd_a: assert property (ce && is_cmd && ((cb == CMD_GET) || (cb == CMD_LPD))
    |=> $stable({remote, lockout, listen_active, talk_active, st.pp_en}))
    else $error("ignored command changed state");
  ppc_arm_a: assert property (ce && is_cmd
    |=> st.ppc_armed == (($past(cb) == CMD_PPC) && $past(st.listen)))
    else $error("configure window wrong");
  ppe_program_a: assert property (ce && c_ppe && st.ppc_armed && st.listen
    |=> st.pp_en && (st.pp_sense == $past(cb[PPE_SENSE_BIT]))
    && (st.response_line_select == $past(cb[2:0])))
    else $error("enable after configure not programmed");
  ppd_gate_a: assert property (ce && is_cmd && (cb == CMD_PPD)
    |=> st.pp_en == ($past(st.pp_en) && !($past(st.ppc_armed) && $past(st.listen))))
    else $error("poll disable gating wrong");
  unlisten_a: assert property (ce && is_cmd && (cb == CMD_UNL) |=> !listen_active)
    else $error("unlisten ignored");
  lad_other_a: assert property (ce && c_lad && (cb[4:0] != st.own_addr)
    |=> listen_active == $past(listen_active))
    else $error("foreign listen address changed state");
  sdc_gate_a: assert property (ce && is_cmd && (cb == CMD_SDC)
    |=> queue_clear == $past(st.listen))
    else $error("selected clear gating wrong");
  idy_async_a: assert property (ce && st.async_mode && data_ready && !st.data_ready_q
    |=> idy_req)
    else $error("identify request missing");
  idy_quiet_a: assert property (ce && !st.async_mode && !(is_cmd && (cb == CMD_EAR))
    |=> !idy_req)
    else $error("identify request outside async mode");
  event_retire_a: assert property (ce && sp_req && ((ev_set & enc_clr) == '0)
    |=> (ev_flags & $past(enc_clr)) == '0)
    else $error("reported event not retired");
  ack_pulse_a: assert property (ce && wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge longer than one cycle");
  sp_pulse_a: assert property (ce && !sp_req |=> !sp_valid)
    else $error("serial poll strobe without a poll");
  pp_pulse_a: assert property (ce && !pp_req |=> !pp_valid)
    else $error("parallel poll strobe without a poll");
endmodule // llp_loop_unit
`default_nettype wire

// file: hw/llp_pkg.sv
// constants shared by the loop listener, talker and poll unit
package llp_pkg;
  // frame class of a loop command frame (upper three bits of the 11-bit frame)
  localparam logic [2:0] FRAME_CMD     = 3'h4;
  // command bytes
  localparam logic [7:0] CMD_GTL       = 8'h01;
  localparam logic [7:0] CMD_SDC       = 8'h04;
  localparam logic [7:0] CMD_PPD       = 8'h05;
  localparam logic [7:0] CMD_GET       = 8'h08;
  localparam logic [7:0] CMD_LLO       = 8'h11;
  localparam logic [7:0] CMD_DCL       = 8'h14;
  localparam logic [7:0] CMD_PPU       = 8'h15;
  localparam logic [7:0] CMD_EAR       = 8'h18;
  localparam logic [7:0] CMD_UNL       = 8'h3f;
  localparam logic [7:0] CMD_UNT       = 8'h5f;
  localparam logic [7:0] CMD_PPC       = 8'h06; // kept clear of the enable block 80-8f
  localparam logic [7:0] CMD_REN       = 8'h92;
  localparam logic [7:0] CMD_NRE       = 8'h93;
  localparam logic [7:0] CMD_LPD       = 8'h9b;
  localparam logic [2:0] GRP_LAD       = 3'h1;
  localparam logic [2:0] GRP_TAD       = 3'h2;
  localparam logic [3:0] GRP_PPE       = 4'h9;
  localparam int         PPE_SENSE_BIT = 3;
  // serial poll status bytes
  localparam logic [7:0] ST_ALL_OK     = 8'h80;
  localparam logic [7:0] ST_LINK       = 8'ha3;
  localparam logic [7:0] ST_INVALID    = 8'hc4;
  localparam logic [7:0] ST_SELFTEST   = 8'hc6;
  localparam logic [7:0] ST_CMD_ERR    = 8'hc7;
  localparam logic [7:0] ST_PANEL_SRQ  = 8'hc9;
  localparam logic [7:0] ST_DATA       = 8'ha2;
  localparam int         ST_SRQ_BIT    = 6;
  localparam int         NUM_EVENTS    = 4;
  // register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATE     = 8'h04;
  localparam logic [7:0] REG_SPOLL     = 8'h08;
  // reset values, and the address field 1f of unlisten and untalk
  localparam logic [4:0] RST_OWN_ADDR  = 5'h01;
  localparam logic       RST_SRQ_DATA  = 1'b0;
  localparam logic [4:0] ADDR_NONE     = 5'h1f;
endpackage : llp_pkg

// file: hw/llp_event_flag.sv
// sticky event flag, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module llp_event_flag
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic set,
  input  wire logic clr,
  output var  logic flag
);
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      flag <= 1'b0;
    else if (ce)
      flag <= set | (flag & ~clr);
  end
endmodule // llp_event_flag
`default_nettype wire

// file: hw/llp_status_enc.sv
// serial poll status byte encoder with event priority
`timescale 1ns/1ps
`default_nettype none
module llp_status_enc
  import llp_pkg::*;
(
  input  wire logic [NUM_EVENTS-1:0] events,
  input  wire logic                  link_state,
  input  wire logic                  data_ready,
  input  wire logic                  srq_data_en,
  output logic      [7:0]            status,
  output logic      [NUM_EVENTS-1:0] clr_sel,
  output logic                       srq
);
  // events outrank states so a fault is never hidden behind data ready
  always_comb
  begin
    clr_sel = '0;
    if (events[0])
    begin
      status = ST_INVALID;
      clr_sel = 4'h1;
    end
    else if (events[1])
    begin
      status = ST_SELFTEST;
      clr_sel = 4'h2;
    end
    else if (events[2])
    begin
      status = ST_CMD_ERR;
      clr_sel = 4'h4;
    end
    else if (events[3])
    begin
      status = ST_PANEL_SRQ;
      clr_sel = 4'h8;
    end
    else if (link_state)
      status = ST_LINK;
    else if (data_ready)
    begin
      status = ST_DATA;
      status[ST_SRQ_BIT] = srq_data_en;
    end
    else
      status = ST_ALL_OK;
    srq = status[ST_SRQ_BIT];
  end
endmodule // llp_status_enc
`default_nettype wire

// file: bench/llp_loop_ctl.sv
// loop controller model: sends command frames and polls the unit
`timescale 1ns/1ps
`default_nettype none
module llp_loop_ctl
  import llp_pkg::*;
(
  input  wire logic        clk_sys,
  output logic             frame_valid,
  output logic      [10:0] frame,
  output logic             sp_req,
  output logic             pp_req,
  output logic      [7:0]  pp_in
);
  initial
  begin
    frame_valid = 1'b0;
    frame       = 11'h0;
    sp_req      = 1'b0;
    pp_req      = 1'b0;
    pp_in       = 8'h0;
  end
  // idle lines carry the inverse of the last value, never a stale copy
  task automatic send_cmd(input logic [7:0] cmd);
    @(posedge clk_sys);
    frame_valid <= 1'b1;
    frame       <= {FRAME_CMD, cmd};
    @(posedge clk_sys);
    frame_valid <= 1'b0;
    frame       <= ~{FRAME_CMD, cmd};
  endtask
  task automatic send_ppe(input logic sense, input logic [2:0] line);
    send_cmd({GRP_PPE[0], 3'h0, sense, line});
  endtask
  task automatic poll(input logic par, input logic [7:0] pin);
    @(posedge clk_sys);
    sp_req <= !par;
    pp_req <= par;
    pp_in  <= pin;
    @(posedge clk_sys);
    sp_req <= 1'b0;
    pp_req <= 1'b0;
    pp_in  <= ~pin;
  endtask
endmodule // llp_loop_ctl
`default_nettype wire

// file: bench/loop_listener_talker_poll_unit_tb_top.sv
// self-checking bench of the loop command interpreter
`timescale 1ns/1ps
`default_nettype none
module loop_listener_talker_poll_unit_tb_top
  import llp_pkg::*;
;
  logic        clk_sys, rst_n, wb_cyc, wb_stb, wb_we, wb_ack_o, link_state, data_ready;
  logic [7:0]  wb_adr, sp_byte, pp_byte, pp_in, pin;
  logic [31:0] wb_dat, wb_dat_o, rd, seed;
  logic        frame_valid, sp_req, pp_req, sp_valid, pp_valid, idy_req, hit, s;
  logic [10:0] frame;
  logic [3:0]  evs, clr4;
  logic [4:0]  own, other;
  logic [2:0]  ln;
  logic        remote, lockout, listen_active, talk_active, srq;
  int          miscompares, compares, i;
  logic [7:0]  codes [4] = '{ST_INVALID, ST_SELFTEST, ST_CMD_ERR, ST_PANEL_SRQ};

  llp_loop_unit uut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_valid(frame_valid),
    .frame(frame), .sp_req(sp_req), .pp_req(pp_req), .pp_in(pp_in), .ev_invalid(evs[0]),
    .ev_selftest(evs[1]), .ev_cmd_err(evs[2]), .ev_panel_srq(evs[3]),
    .link_state(link_state), .data_ready(data_ready), .sp_byte(sp_byte),
    .sp_valid(sp_valid), .pp_byte(pp_byte), .pp_valid(pp_valid), .idy_req(idy_req),
    .queue_clear(clr4[0]), .meas_abort(clr4[1]), .mode_normal(clr4[2]),
    .direct_exit(clr4[3]), .remote(remote), .lockout(lockout),
    .listen_active(listen_active), .talk_active(talk_active), .srq(srq));
  llp_loop_ctl ctl (.clk_sys(clk_sys), .frame_valid(frame_valid), .frame(frame),
    .sp_req(sp_req), .pp_req(pp_req), .pp_in(pp_in));

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic finish_test;
    if (miscompares == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_dat <= dat;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      miscompares++;
      finish_test();
    end
  endtask
  // polls and checks the status byte together with its strobe
  task automatic spoll(input logic [7:0] exp);
    ctl.poll(1'b0, 8'h0);
    #1 chk({sp_valid, sp_byte}, {1'b1, exp});
  endtask
  task automatic ppoll(input logic en, input logic sn, input logic q, input logic [7:0] p);
    ctl.poll(1'b1, p);
    #1 chk({pp_valid, pp_byte}, {1'b1, exp_pp(p, en, sn, ln, q)});
  endtask
  task automatic idy_watch;
    hit = 1'b0;
    repeat (4)
    begin
      @(posedge clk_sys);
      #1 hit = hit | (idy_req === 1'b1);
    end
  endtask
  function automatic logic [7:0] exp_pp(input logic [7:0] p, input logic en, input logic sn,
                                         input logic [2:0] l, input logic q);
    exp_pp = p;
    if (en)
      exp_pp[l] = p[l] | (sn ? q : !q);
  endfunction

  initial
  begin
    seed = 32'hd562;
    {rst_n, wb_cyc, wb_stb, wb_we, link_state, data_ready} = '0;
    {wb_adr, wb_dat, evs, ln} = '0;
    miscompares = 0;
    compares = 0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 chk({sp_byte, remote, lockout, listen_active, talk_active, srq}, {ST_ALL_OK, 5'h0});
    wb(1'b0, REG_SPOLL, 32'h0);
    chk(rd, {24'h0, ST_ALL_OK});
    wb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    own = 5'($unsigned($random(seed)) % 31);
    other = (own == 5'd30) ? 5'd0 : own + 5'd1;
    wb(1'b1, REG_CTRL, {27'h0, own});
    ctl.send_cmd({GRP_LAD, other});
    #1 chk(listen_active, 1'b0);
    ctl.send_cmd({GRP_LAD, own});
    #1 chk(listen_active, 1'b1);
    ctl.send_cmd(CMD_UNL);
    #1 chk(listen_active, 1'b0);
    ctl.send_cmd({GRP_TAD, own});
    #1 chk(talk_active, 1'b1);
    ctl.send_cmd({GRP_TAD, other});
    #1 chk(talk_active, 1'b0);
    ctl.send_cmd({GRP_TAD, own});
    ctl.send_cmd(CMD_UNT);
    #1 chk(talk_active, 1'b0);
    ctl.send_cmd(CMD_LLO);
    #1 chk(lockout, 1'b0);
    ctl.send_cmd(CMD_REN);
    ctl.send_cmd(CMD_GTL);
    #1 chk(remote, 1'b1);
    ctl.send_cmd(CMD_LLO);
    ctl.send_cmd(CMD_GET);
    ctl.send_cmd(CMD_LPD);
    #1 chk({remote, lockout}, 2'b11);
    ctl.send_cmd(CMD_NRE);
    #1 chk({remote, lockout}, 2'b00);
    ctl.send_cmd(CMD_REN);
    ctl.send_cmd({GRP_LAD, own});
    ctl.send_cmd(CMD_GTL);
    #1 chk(remote, 1'b0);
    ctl.send_cmd(CMD_SDC);
    #1 chk(clr4, 4'hf);
    ctl.send_cmd(CMD_DCL);
    #1 chk(clr4, 4'hf);
    for (i = 0; i < 4; i++)
    begin
      s = 1'($random(seed));
      ln = 3'($random(seed));
      ctl.send_cmd(CMD_PPC);
      ctl.send_ppe(s, ln);
      ppoll(1'b1, s, 1'b0, 8'($random(seed)));
    end
    // sense 0 with the line low in the poll byte shows enabled or not
    pin = 8'($random(seed)) & ~(8'h1 << ln);
    ctl.send_cmd(CMD_PPC);
    ctl.send_cmd(CMD_PPD);
    ppoll(1'b0, 1'b0, 1'b0, pin);
    ctl.send_ppe(1'b0, ln);
    ppoll(1'b0, 1'b0, 1'b0, pin);
    ctl.send_cmd(CMD_PPC);
    ctl.send_ppe(1'b0, ln);
    ctl.send_cmd(CMD_UNL);
    ctl.send_cmd(CMD_PPU);
    ppoll(1'b0, 1'b0, 1'b0, pin);
    ctl.send_cmd({GRP_LAD, own});
    ctl.send_cmd(CMD_PPC);
    ctl.send_ppe(1'b1, ln);
    wb(1'b0, REG_STATE, 32'h0);
    chk(rd, {21'h0, ln, 8'hc4});
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      evs <= 4'h1 << i;
      @(posedge clk_sys);
      evs <= 4'h0;
      repeat (2) @(posedge clk_sys);
      #1 chk(srq, 1'b1);
      ppoll(1'b1, 1'b1, 1'b1, pin);
      spoll(codes[i]);
      spoll(ST_ALL_OK);
    end
    @(posedge clk_sys);
    evs <= 4'b0110;
    @(posedge clk_sys);
    evs <= 4'h0;
    spoll(ST_SELFTEST);
    spoll(ST_CMD_ERR);
    @(posedge clk_sys);
    data_ready <= 1'b1;
    spoll(ST_DATA);
    spoll(ST_DATA);
    wb(1'b1, REG_CTRL, {23'h0, 1'b1, 3'h0, own});
    spoll(ST_DATA | 8'h40);
    @(posedge clk_sys);
    link_state <= 1'b1;
    spoll(ST_LINK);
    @(posedge clk_sys);
    {link_state, data_ready} <= 2'b00;
    ctl.send_cmd(CMD_EAR);
    data_ready <= 1'b1;
    idy_watch();
    chk(hit, 1'b1);
    @(posedge clk_sys);
    data_ready <= 1'b0;
    ctl.send_cmd(CMD_EAR);
    ctl.send_cmd(CMD_GET);
    data_ready <= 1'b1;
    idy_watch();
    chk(hit, 1'b0);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 chk({remote, lockout, listen_active, talk_active, srq}, 5'h0);
    wb(1'b0, REG_CTRL, 32'h0);
    chk(rd, {27'h0, RST_OWN_ADDR});
    wb(1'b0, REG_STATE, 32'h0);
    chk(rd, 32'h0);
    finish_test();
  end
endmodule // loop_listener_talker_poll_unit_tb_top
`default_nettype wire
